// *** spm_far_model.sv ***
/*
  Far-side model: serial codecs on the port pads plus the board strap.
  Assumes the pad vectors are packed by the bench, one bit per pad.
*/
`timescale 1ns/1ps
`default_nettype none

module spm_far_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        strap_want,
  input  wire logic [11:0] pad_out,
  input  wire logic [11:0] pad_oe_n,
  output var  logic [11:0] pad_level,
  output var  logic        function_strap
);
  // =========================================================================
  // codec drive pattern
  logic [11:0] pattern;

  // inverts every cycle so a stale or late sample never matches by luck
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pattern <= 12'h5a3;
    end else begin
      pattern <= ~pattern;
    end
  end

  // device drive wins, otherwise the codec shows its pattern
  always_comb begin
    for (int k = 0; k < 12; k++) begin
      pad_level[k] = pad_oe_n[k] ? pattern[k] : pad_out[k];
    end
  end

  // board holds the strap steady at the wanted level
  assign function_strap = strap_want;
endmodule

`default_nettype wire

// *** spm_pin_mux.sv ***
/*
  Pin mux and reset-time pad states for three synchronous serial ports and
  the shared pins of the third port.
  Assumes the serial engines, the uart and the io logic sit on the engine
  side, keep their own enables low until software turns them on, and that
  the strap is steady for the whole reset period.
*/
`timescale 1ns/1ps
`default_nettype none

module spm_pin_mux
  import spm_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic function_strap,
  output var  logic function_select,
  // port 0
  input  wire logic port0_tx_data_out,
  input  wire logic port0_tx_data_oe,
  output var  logic port0_tx_data_pad_out,
  output var  logic port0_tx_data_pad_oe_n,
  input  wire logic port0_tx_frame_sync_out,
  input  wire logic port0_tx_frame_sync_oe,
  output var  logic port0_tx_frame_sync_in,
  input  wire logic port0_tx_frame_sync_pad_in,
  output var  logic port0_tx_frame_sync_pad_out,
  output var  logic port0_tx_frame_sync_pad_oe_n,
  // port 1
  input  wire logic port1_tx_data_out,
  input  wire logic port1_tx_data_oe,
  output var  logic port1_tx_data_pad_out,
  output var  logic port1_tx_data_pad_oe_n,
  input  wire logic port1_rx_clock_out,
  input  wire logic port1_rx_clock_oe,
  output var  logic port1_rx_clock_in,
  input  wire logic port1_rx_clock_pad_in,
  output var  logic port1_rx_clock_pad_out,
  output var  logic port1_rx_clock_pad_oe_n,
  input  wire logic port1_rx_frame_sync_out,
  input  wire logic port1_rx_frame_sync_oe,
  output var  logic port1_rx_frame_sync_in,
  input  wire logic port1_rx_frame_sync_pad_in,
  output var  logic port1_rx_frame_sync_pad_out,
  output var  logic port1_rx_frame_sync_pad_oe_n,
  input  wire logic port1_tx_clock_out,
  input  wire logic port1_tx_clock_oe,
  output var  logic port1_tx_clock_in,
  input  wire logic port1_tx_clock_pad_in,
  output var  logic port1_tx_clock_pad_out,
  output var  logic port1_tx_clock_pad_oe_n,
  input  wire logic port1_tx_frame_sync_out,
  input  wire logic port1_tx_frame_sync_oe,
  output var  logic port1_tx_frame_sync_in,
  input  wire logic port1_tx_frame_sync_pad_in,
  output var  logic port1_tx_frame_sync_pad_out,
  output var  logic port1_tx_frame_sync_pad_oe_n,
  // port 2 and shared pin functions
  input  wire logic port2_tx_data_out,
  input  wire logic port2_tx_data_oe,
  output var  logic port2_tx_data_pad_out,
  output var  logic port2_tx_data_pad_oe_n,
  input  wire logic io_line_3_out,
  input  wire logic io_line_3_oe,
  output var  logic io_line_3_in,
  input  wire logic port2_tx_clock_out,
  input  wire logic port2_tx_clock_oe,
  output var  logic port2_tx_clock_in,
  input  wire logic uart_tx,
  input  wire logic port2_rx_clock_out,
  input  wire logic port2_rx_clock_oe,
  output var  logic port2_rx_clock_in,
  input  wire logic io_line_5_out,
  input  wire logic io_line_5_oe,
  output var  logic io_line_5_in,
  input  wire logic port2_tx_frame_sync_out,
  input  wire logic port2_tx_frame_sync_oe,
  output var  logic port2_tx_frame_sync_in,
  output var  logic uart_rx,
  input  wire logic port2_rx_frame_sync_out,
  input  wire logic port2_rx_frame_sync_oe,
  output var  logic port2_rx_frame_sync_in,
  // shared pads
  input  wire logic shared_pin_0_in,
  output var  logic shared_pin_0_out,
  output var  logic shared_pin_0_oe_n,
  input  wire logic shared_pin_1_in,
  output var  logic shared_pin_1_out,
  output var  logic shared_pin_1_oe_n,
  input  wire logic shared_pin_2_in,
  output var  logic shared_pin_2_out,
  output var  logic shared_pin_2_oe_n,
  input  wire logic shared_pin_3_in,
  output var  logic shared_pin_3_out,
  output var  logic shared_pin_3_oe_n
);

  // =========================================================================
  // reset tracking and strap capture
  spm_state_t state;
  spm_state_t next_state;
  logic       next_select;
  logic       active;

  // the strap follows the pin on every edge while in reset, freezes after
  always_comb begin
    next_state  = SPM_LATCHED;
    next_select = function_select;
    case (state)
      SPM_IN_RESET: begin
        next_select = function_strap;
      end
      SPM_LATCHED: begin
        next_select = function_select;
      end
      default: begin
        next_state = SPM_IN_RESET;
      end
    endcase
  end

  assign active = (state == SPM_LATCHED);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= SPM_IN_RESET;
    end else begin
      state <= next_state;
    end
  end

  // no reset here: an async reset could only load a constant, not the strap
  always_ff @(posedge clock) begin
    function_select <= next_select;
  end

  // =========================================================================
  // pad outputs and routed inputs
  logic [1:0] next_p0_txd, next_p0_fsx, next_p1_txd, next_p1_clkr, next_p1_fsr;
  logic [1:0] next_p1_clkx, next_p1_fsx, next_p2_txd, next_shared_0, next_shared_1;
  logic [1:0] next_shared_2, next_shared_3;
  logic [10:0] next_ins;
  logic        serial;

  assign serial = (function_select == STRAP_SERIAL);

  // every pad but shared pin 1 in io mode floats until latched; the engines then steer their own enables, except shared pin 3 in io mode, which stays floating
  always_comb begin
    next_p0_txd  = spm_pad_drive(active, port0_tx_data_out, port0_tx_data_oe);
    next_p0_fsx  = spm_pad_drive(active, port0_tx_frame_sync_out,
                                 port0_tx_frame_sync_oe);
    next_p1_txd  = spm_pad_drive(active, port1_tx_data_out, port1_tx_data_oe);
    next_p1_clkr = spm_pad_drive(active, port1_rx_clock_out, port1_rx_clock_oe);
    next_p1_fsr  = spm_pad_drive(active, port1_rx_frame_sync_out,
                                 port1_rx_frame_sync_oe);
    next_p1_clkx = spm_pad_drive(active, port1_tx_clock_out, port1_tx_clock_oe);
    next_p1_fsx  = spm_pad_drive(active, port1_tx_frame_sync_out,
                                 port1_tx_frame_sync_oe);
    next_p2_txd  = spm_pad_drive(active, port2_tx_data_out, port2_tx_data_oe);
    if (serial) begin
      next_shared_0 = spm_pad_drive(active, port2_tx_clock_out,
                                    port2_tx_clock_oe);
      next_shared_1 = spm_pad_drive(active, port2_rx_clock_out,
                                    port2_rx_clock_oe);
      next_shared_2 = spm_pad_drive(active, port2_tx_frame_sync_out,
                                    port2_tx_frame_sync_oe);
      next_shared_3 = spm_pad_drive(active, port2_rx_frame_sync_out,
                                    port2_rx_frame_sync_oe);
    end else begin
      next_shared_0 = spm_pad_drive(active, io_line_3_out, io_line_3_oe);
      next_shared_1 = {active ? uart_tx : UART_IDLE, OE_N_ON};
      next_shared_2 = spm_pad_drive(active, io_line_5_out, io_line_5_oe);
      next_shared_3 = {IN_RESET_VAL, OE_N_OFF};
    end
    // unselected functions see a quiet level instead of the other's traffic
    next_ins = {port0_tx_frame_sync_pad_in, port1_rx_clock_pad_in,
                port1_rx_frame_sync_pad_in, port1_tx_clock_pad_in,
                port1_tx_frame_sync_pad_in,
                serial ? IN_RESET_VAL : shared_pin_0_in,
                serial ? shared_pin_0_in : IN_RESET_VAL,
                serial ? shared_pin_1_in : IN_RESET_VAL,
                serial ? IN_RESET_VAL : shared_pin_2_in,
                serial ? shared_pin_2_in : IN_RESET_VAL,
                serial ? shared_pin_3_in : IN_RESET_VAL};
  end

  // pads reset to floating; shared pin 1 is kept apart, see below
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {port0_tx_data_pad_out, port0_tx_data_pad_oe_n}             <= {IN_RESET_VAL, OE_N_OFF};
      {port0_tx_frame_sync_pad_out, port0_tx_frame_sync_pad_oe_n} <= {IN_RESET_VAL, OE_N_OFF};
      {port1_tx_data_pad_out, port1_tx_data_pad_oe_n}             <= {IN_RESET_VAL, OE_N_OFF};
      {port1_rx_clock_pad_out, port1_rx_clock_pad_oe_n}           <= {IN_RESET_VAL, OE_N_OFF};
      {port1_rx_frame_sync_pad_out, port1_rx_frame_sync_pad_oe_n} <= {IN_RESET_VAL, OE_N_OFF};
      {port1_tx_clock_pad_out, port1_tx_clock_pad_oe_n}           <= {IN_RESET_VAL, OE_N_OFF};
      {port1_tx_frame_sync_pad_out, port1_tx_frame_sync_pad_oe_n} <= {IN_RESET_VAL, OE_N_OFF};
      {port2_tx_data_pad_out, port2_tx_data_pad_oe_n}             <= {IN_RESET_VAL, OE_N_OFF};
      {shared_pin_0_out, shared_pin_0_oe_n}                       <= {IN_RESET_VAL, OE_N_OFF};
      {shared_pin_2_out, shared_pin_2_oe_n}                       <= {IN_RESET_VAL, OE_N_OFF};
      {shared_pin_3_out, shared_pin_3_oe_n}                       <= {IN_RESET_VAL, OE_N_OFF};
      {port0_tx_frame_sync_in, port1_rx_clock_in, port1_rx_frame_sync_in,
       port1_tx_clock_in, port1_tx_frame_sync_in, io_line_3_in,
       port2_tx_clock_in, port2_rx_clock_in, io_line_5_in,
       port2_tx_frame_sync_in, port2_rx_frame_sync_in} <= 11'h000;
      uart_rx <= UART_IDLE;
    end else begin
      {port0_tx_data_pad_out, port0_tx_data_pad_oe_n}             <= next_p0_txd;
      {port0_tx_frame_sync_pad_out, port0_tx_frame_sync_pad_oe_n} <= next_p0_fsx;
      {port1_tx_data_pad_out, port1_tx_data_pad_oe_n}             <= next_p1_txd;
      {port1_rx_clock_pad_out, port1_rx_clock_pad_oe_n}           <= next_p1_clkr;
      {port1_rx_frame_sync_pad_out, port1_rx_frame_sync_pad_oe_n} <= next_p1_fsr;
      {port1_tx_clock_pad_out, port1_tx_clock_pad_oe_n}           <= next_p1_clkx;
      {port1_tx_frame_sync_pad_out, port1_tx_frame_sync_pad_oe_n} <= next_p1_fsx;
      {port2_tx_data_pad_out, port2_tx_data_pad_oe_n}             <= next_p2_txd;
      {shared_pin_0_out, shared_pin_0_oe_n}                       <= next_shared_0;
      {shared_pin_2_out, shared_pin_2_oe_n}                       <= next_shared_2;
      {shared_pin_3_out, shared_pin_3_oe_n}                       <= next_shared_3;
      {port0_tx_frame_sync_in, port1_rx_clock_in, port1_rx_frame_sync_in,
       port1_tx_clock_in, port1_tx_frame_sync_in, io_line_3_in,
       port2_tx_clock_in, port2_rx_clock_in, io_line_5_in,
       port2_tx_frame_sync_in, port2_rx_frame_sync_in} <= next_ins;
      uart_rx <= serial ? UART_IDLE : shared_pin_3_in;
    end
  end

  // shared pin 1 must drive 1 in reset only if the strap says uart, so it
  // cannot take a constant reset; it follows the live strap while in reset
  always_ff @(posedge clock) begin
    {shared_pin_1_out, shared_pin_1_oe_n} <= next_shared_1;
  end

  // =========================================================================
  // checks
  a_sel_at_release: assert property (@(posedge clock) disable iff (!resetn)
    $rose(active) |-> function_select == $past(function_strap))
    else $error("choice not taken from strap at release");

  a_sel_held: assert property (@(posedge clock) disable iff (!resetn)
    active && $past(active) |-> $stable(function_select))
    else $error("choice changed after release");

  a_tx_float_release: assert property (@(posedge clock) disable iff (!resetn)
    $rose(active) |-> port0_tx_data_pad_oe_n && port1_tx_data_pad_oe_n
                      && port2_tx_data_pad_oe_n)
    else $error("transmit data driven at release");

  a_tx0_gated: assert property (@(posedge clock) disable iff (!resetn)
    active && !port0_tx_data_oe |=> port0_tx_data_pad_oe_n == OE_N_OFF)
    else $error("port 0 data driven without enable");

  a_ctl_inputs: assert property (@(posedge clock) disable iff (!resetn)
    $rose(active) |-> port0_tx_frame_sync_pad_oe_n && port1_rx_clock_pad_oe_n
      && port1_rx_frame_sync_pad_oe_n && port1_tx_clock_pad_oe_n
      && port1_tx_frame_sync_pad_oe_n && shared_pin_0_oe_n
      && shared_pin_2_oe_n)
    else $error("control pad driven at release");

  a_shared0_route: assert property (@(posedge clock) disable iff (!resetn)
    active && serial ##1 active |-> shared_pin_0_out == $past(port2_tx_clock_out)
      && shared_pin_0_oe_n == !$past(port2_tx_clock_oe))
    else $error("shared pin 0 misrouted");

  a_uart_tx_idle: assert property (@(posedge clock) disable iff (!resetn)
    !serial && !active |=> shared_pin_1_oe_n == OE_N_ON
      && shared_pin_1_out == UART_IDLE)
    else $error("uart transmit not high in reset");

  a_shared1_route: assert property (@(posedge clock) disable iff (!resetn)
    active && !serial |=> shared_pin_1_out == $past(uart_tx)
      && shared_pin_1_oe_n == OE_N_ON)
    else $error("shared pin 1 not carrying uart");

  a_shared2_route: assert property (@(posedge clock) disable iff (!resetn)
    active && !serial |=> shared_pin_2_out == $past(io_line_5_out)
      && io_line_5_in == $past(shared_pin_2_in))
    else $error("shared pin 2 misrouted");

  a_shared3_route: assert property (@(posedge clock) disable iff (!resetn)
    active && !serial |=> shared_pin_3_oe_n == OE_N_OFF
      && uart_rx == $past(shared_pin_3_in))
    else $error("shared pin 3 not feeding uart");

endmodule

`default_nettype wire

// *** spm_pin_mux_tb_top.sv ***
/*
  Testbench for the serial port pin mux: reset states, strap latching,
  shared pin routing and input paths, for both strap levels.
  Assumes the pin mux ports as declared and the far model alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module spm_pin_mux_tb_top;
  import spm_pkg::*;
  logic        clock;
  logic        resetn;
  logic        uart_tx;
  logic        strap_want;
  logic [13:0] eo;
  logic [13:0] ee;
  wire  [11:0] po;
  wire  [11:0] pn;
  wire  [11:0] pi;
  wire  [11:0] ei;
  wire         function_strap;
  wire         function_select;
  int          mismatches;
  int          n_compared;
  localparam logic [13:0] PAT = 14'h2b5c;

  // =========================================================================
  // design and far side
  spm_pin_mux spm_pin_mux_i (
    .clock(clock), .resetn(resetn), .function_strap(function_strap),
    .function_select(function_select),
    .port0_tx_data_out(eo[0]), .port0_tx_data_oe(ee[0]),
    .port0_tx_data_pad_out(po[0]), .port0_tx_data_pad_oe_n(pn[0]),
    .port1_tx_data_out(eo[1]), .port1_tx_data_oe(ee[1]),
    .port1_tx_data_pad_out(po[1]), .port1_tx_data_pad_oe_n(pn[1]),
    .port2_tx_data_out(eo[2]), .port2_tx_data_oe(ee[2]),
    .port2_tx_data_pad_out(po[2]), .port2_tx_data_pad_oe_n(pn[2]),
    .port0_tx_frame_sync_out(eo[3]), .port0_tx_frame_sync_oe(ee[3]),
    .port0_tx_frame_sync_in(ei[0]), .port0_tx_frame_sync_pad_in(pi[3]),
    .port0_tx_frame_sync_pad_out(po[3]), .port0_tx_frame_sync_pad_oe_n(pn[3]),
    .port1_rx_clock_out(eo[4]), .port1_rx_clock_oe(ee[4]),
    .port1_rx_clock_in(ei[1]), .port1_rx_clock_pad_in(pi[4]),
    .port1_rx_clock_pad_out(po[4]), .port1_rx_clock_pad_oe_n(pn[4]),
    .port1_rx_frame_sync_out(eo[5]), .port1_rx_frame_sync_oe(ee[5]),
    .port1_rx_frame_sync_in(ei[2]), .port1_rx_frame_sync_pad_in(pi[5]),
    .port1_rx_frame_sync_pad_out(po[5]), .port1_rx_frame_sync_pad_oe_n(pn[5]),
    .port1_tx_clock_out(eo[6]), .port1_tx_clock_oe(ee[6]),
    .port1_tx_clock_in(ei[3]), .port1_tx_clock_pad_in(pi[6]),
    .port1_tx_clock_pad_out(po[6]), .port1_tx_clock_pad_oe_n(pn[6]),
    .port1_tx_frame_sync_out(eo[7]), .port1_tx_frame_sync_oe(ee[7]),
    .port1_tx_frame_sync_in(ei[4]), .port1_tx_frame_sync_pad_in(pi[7]),
    .port1_tx_frame_sync_pad_out(po[7]), .port1_tx_frame_sync_pad_oe_n(pn[7]),
    .io_line_3_out(eo[8]), .io_line_3_oe(ee[8]), .io_line_3_in(ei[5]),
    .port2_tx_clock_out(eo[9]), .port2_tx_clock_oe(ee[9]), .port2_tx_clock_in(ei[6]),
    .uart_tx(uart_tx),
    .port2_rx_clock_out(eo[10]), .port2_rx_clock_oe(ee[10]), .port2_rx_clock_in(ei[7]),
    .io_line_5_out(eo[11]), .io_line_5_oe(ee[11]), .io_line_5_in(ei[8]),
    .port2_tx_frame_sync_out(eo[12]), .port2_tx_frame_sync_oe(ee[12]),
    .port2_tx_frame_sync_in(ei[9]), .uart_rx(ei[10]),
    .port2_rx_frame_sync_out(eo[13]), .port2_rx_frame_sync_oe(ee[13]),
    .port2_rx_frame_sync_in(ei[11]),
    .shared_pin_0_in(pi[8]), .shared_pin_0_out(po[8]), .shared_pin_0_oe_n(pn[8]),
    .shared_pin_1_in(pi[9]), .shared_pin_1_out(po[9]), .shared_pin_1_oe_n(pn[9]),
    .shared_pin_2_in(pi[10]), .shared_pin_2_out(po[10]), .shared_pin_2_oe_n(pn[10]),
    .shared_pin_3_in(pi[11]), .shared_pin_3_out(po[11]), .shared_pin_3_oe_n(pn[11])
  );

  spm_far_model spm_far_model_i (
    .clock(clock), .resetn(resetn), .strap_want(strap_want), .pad_out(po),
    .pad_oe_n(pn), .pad_level(pi), .function_strap(function_strap)
  );

  // =========================================================================
  // clock, watchdog and shared tasks
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // a hang ends the run as a mismatch
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    conclude();
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // floating pads, except the uart line which idles driven in io mode
  function automatic logic [11:0] idle_oe_n(input logic s);
    return s ? 12'hfff : 12'hdff;
  endfunction

  // =========================================================================
  // scenarios
  // engine enables asserted in reset must be refused
  task automatic reset_phase(input logic s);
    @(posedge clock);
    resetn <= 1'h0;
    strap_want <= s;
    ee <= '1;
    eo <= '1;
    uart_tx <= 1'h1;
    step(20);
    chk("oe_n in reset", idle_oe_n(s), pn);
    if (!s) chk("uart in reset", 12'h1, {11'h0, po[9]});
    @(posedge clock);
    ee <= '0;
    resetn <= 1'h1;
    step(2);
    chk("select", {11'h0, s}, {11'h0, function_select});
    chk("oe_n after reset", idle_oe_n(s), pn);
    if (!s) chk("uart after reset", 12'h1, {11'h0, po[9]});
  endtask

  // engine drive reaches the pads one cycle later, on the selected pins
  task automatic pad_check(input logic s);
    logic [11:0] e;
    @(posedge clock);
    eo <= PAT;
    ee <= '1;
    uart_tx <= 1'h0;
    step(1);
    e[7:0] = PAT[7:0];
    e[11:8] = s ? {PAT[13], PAT[12], PAT[10], PAT[9]} : {1'h0, PAT[11], 1'h0, PAT[8]};
    chk("pad out", e, po);
    chk("pad oe_n", s ? 12'h000 : 12'h800, pn);
    @(posedge clock);
    ee <= '0;
    uart_tx <= 1'h1;
    step(1);
    chk("released oe_n", idle_oe_n(s), pn);
  endtask

  // pad levels reach the selected engine inputs one cycle late
  task automatic in_check(input logic s);
    logic [11:0] sv;
    logic [11:0] e;
    sv = pi;
    step(1);
    e = 12'h0;
    e[4:0] = sv[7:3];
    if (s) begin
      {e[11], e[10], e[9], e[7], e[6]} = {sv[11], 1'h1, sv[10], sv[9], sv[8]};
    end else begin
      {e[10], e[8], e[5]} = {sv[11], sv[10], sv[8]};
    end
    chk("engine in", e, ei);
  endtask

  // later strap changes leave the choice alone
  task automatic hold_phase(input logic s);
    @(posedge clock);
    strap_want <= ~s;
    step(3);
    chk("held select", {11'h0, s}, {11'h0, function_select});
    pad_check(s);
    in_check(s);
  endtask

  // =========================================================================
  // main sequence
  initial begin
    mismatches = 0;
    n_compared = 0;
    resetn = 1'h0;
    strap_want = 1'h0;
    uart_tx = 1'h1;
    eo = '0;
    ee = '0;
    step(20);
    for (int i = 0; i < 2; i++) begin
      reset_phase(i[0]);
      pad_check(i[0]);
      in_check(i[0]);
      hold_phase(i[0]);
    end
    conclude();
  end
endmodule

`default_nettype wire

// *** spm_pkg.sv ***
/*
  Constants, state type and a helper function for the serial port pin mux.
  Assumes one 50 MHz clock and an asynchronous, active-low reset.
*/
`default_nettype none

package spm_pkg;

  // =========================================================================
  // strap and pad encodings
  localparam logic STRAP_GPIO   = 1'h0; // io lines and uart on shared pins
  localparam logic STRAP_SERIAL = 1'h1; // port 2 clocks and syncs on shared pins
  localparam logic OE_N_ON      = 1'h0; // pad driven
  localparam logic OE_N_OFF     = 1'h1; // pad floats
  localparam logic UART_IDLE    = 1'h1; // uart line level at rest
  localparam logic IN_RESET_VAL = 1'h0; // value of a routed input at reset

  // =========================================================================
  // reset tracking state
  typedef enum logic {
    SPM_IN_RESET,
    SPM_LATCHED
  } spm_state_t;

  // =========================================================================
  // pad drive: output level and active-low enable, driven only once latched
  function automatic logic [1:0] spm_pad_drive(input logic active,
                                               input logic data,
                                               input logic oe);
    spm_pad_drive = {data, (active && oe) ? OE_N_ON : OE_N_OFF};
  endfunction

endpackage

`default_nettype wire
